/* File: src/ssd_defs.svh */
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH
// clock rate and alarm reset hold time
`define SSD_CLK_MHZ     100
`define SSD_ALM_RST_MS  120
// register byte offsets
`define SSD_REG_CFG     8'h00
`define SSD_REG_TLIM    8'h04
`define SSD_REG_GEAR    8'h08
`define SSD_REG_SPEXT   8'h0c
`define SSD_REG_SPTAB   8'h10
`define SSD_REG_STAT    8'h14
`define SSD_REG_DEV     8'h18
// configuration word fields
`define SSD_F_ZSD       1:0
`define SSD_F_VIB       2
`define SSD_F_TLS       5:4
`define SSD_F_GMODE     6
`define SSD_F_GAUX      9:8
`define SSD_F_CMODE     14:12
`define SSD_F_IPGEN     16
`define SSD_F_PORT      17
`define SSD_F_FMT       19:18
`define SSD_F_STOP      21:20
`define SSD_F_INTSP     22
`define SSD_F_TIDX      18:16
// reset values
`define SSD_CFG_RST     32'h0001_0000
`define SSD_TLIM_RST    32'h0000_0000
`define SSD_GEAR_RST    32'h0001_0001
`define SSD_SPEXT_RST   16'h0000
// setting codes
`define SSD_ZSD_ZERO    2'h1
`define SSD_ZSD_DIR     2'h2
`define SSD_TLS_SWITCH  2'h3
`define SSD_FMT_QUAD    2'h0
`define SSD_FMT_CWCCW   2'h1
`define SSD_FMT_FEED    2'h2
`define SSD_CM_POS      3'h0
`define SSD_CM_SPD      3'h1
`define SSD_CM_TRQ      3'h2
`define SSD_CM_POS_SPD  3'h3
`define SSD_CM_POS_TRQ  3'h4
`define SSD_CM_SPD_TRQ  3'h5
`endif

/* File: src/ssd_pkg.sv */
package ssd_pkg;
    // active control mode
    typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ} ssd_mode_e;
    // servo power state
    typedef enum logic [1:0] {SV_OFF, SV_ON, SV_ALARM} ssd_servo_e;
    // synchronised input pins, msb first
    typedef struct packed {
        logic servo_on;
        logic alarm_reset;
        logic mode_sw;
        logic pin26;
        logic pin27;
        logic pin28;
        logic pin30;
        logic pin33;
        logic ld_a;
        logic ld_b;
        logic oc_a;
        logic oc_b;
    } ssd_pins_s;
    // one decoded command step
    typedef struct packed {
        logic up;
        logic dn;
    } ssd_step_s;
endpackage : ssd_pkg

/* File: src/ssd_speed_mem.sv */
`timescale 1ns/10ps
module ssd_speed_mem (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [2:0]  rd_addr,
    output logic      [15:0] rd_data
);
    logic [15:0] mem [8];
    logic [15:0] rd_data_ff;

    // table of internally stored speeds
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // registered read port
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rd_data_ff <= 16'h0000;
        else
            rd_data_ff <= mem[rd_addr];
    end

    assign rd_data = rd_data_ff;
endmodule : ssd_speed_mem

/* File: src/ssd_pulse_dec.sv */
`timescale 1ns/10ps
`include "ssd_defs.svh"
module ssd_pulse_dec (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] fmt,
    input  wire logic       line_a,
    input  wire logic       line_b,
    output ssd_pkg::ssd_step_s step
);
    logic               a_ff;
    logic               b_ff;
    ssd_pkg::ssd_step_s step_ff;
    ssd_pkg::ssd_step_s nxt_step;

    // previous line levels for edge detection
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            a_ff <= 1'b0;
            b_ff <= 1'b0;
        end
        else
        begin
            a_ff <= line_a;
            b_ff <= line_b;
        end
    end

    // RULE20 format decode select
    always_comb
    begin
        nxt_step = '0;
        case (fmt)
            `SSD_FMT_CWCCW:
            begin
                nxt_step.dn = line_a & ~a_ff;  // reverse train
                nxt_step.up = line_b & ~b_ff;  // forward train
            end
            `SSD_FMT_FEED:
            begin
                nxt_step.dn = line_a & ~a_ff & line_b;
                nxt_step.up = line_a & ~a_ff & ~line_b;
            end
            `SSD_FMT_QUAD:
            begin
                // count every edge, both lines moving is dropped
                if ((line_a ^ a_ff) ^ (line_b ^ b_ff))
                begin
                    nxt_step.up = a_ff ^ line_b;
                    nxt_step.dn = ~(a_ff ^ line_b);
                end
            end
            default: nxt_step = '0;
        endcase
    end

    // registered step output
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            step_ff <= '0;
        else
            step_ff <= nxt_step;
    end

    assign step = step_ff;
endmodule : ssd_pulse_dec

/* File: src/ssd_top.sv */
// Summary of operation
// RULE1 - zero-speed input used only when setting 1
// RULE2 - inactive zero-speed input forces speed zero
// RULE3 - setting 2 makes input select direction
// RULE4 - filter input picks filter pair one/two
// RULE5 - gain switch only when torque setting 0-2
// RULE6 - mode 0: inactive PI, active P-only
// RULE7 - mode 1: toggles gain sets, two modifiers
// RULE8 - torque setting 3 selects limit one/two
// RULE9 - position mode gear input picks numerator
// RULE10 - host sends no pulses 10 ms around switch
// RULE11 - speed mode three inputs pick stored speed
// RULE12 - servo-on input energises motor, off stops
// RULE13 - stop setting picks braking and counter clear
// RULE14 - clear input clears counter, held 100 us; the code clears once the input passes the two flip-flops, with no hold check
// RULE15 - alarm reset clears alarm, held 120 ms
// RULE16 - good alarm reset clears counter, some stay
// RULE17 - mode switch works only for settings 3-5
// RULE18 - inhibit enabled and input off drops pulses
// RULE19 - port setting 1 uses line-driver pulses
// RULE20 - format setting picks pulse decode method
// RULE21 - pin meaning follows active control mode
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "ssd_defs.svh"
module ssd_top #(
    parameter int unsigned ALM_RST_CYC = `SSD_ALM_RST_MS * 1000 * `SSD_CLK_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        zero_speed_in,
    input  wire logic        gain_switch_in,
    input  wire logic        gear_num_sel_in,
    input  wire logic        dev_counter_clear_in,
    input  wire logic        pulse_inhibit_in,
    input  wire logic        ctrl_mode_switch_in,
    input  wire logic        servo_on_in,
    input  wire logic        alarm_reset_in,
    input  wire logic        ld_rev_pulse_p,
    input  wire logic        ld_fwd_pulse_p,
    input  wire logic        oc_rev_pulse,
    input  wire logic        oc_fwd_pulse,
    input  wire logic        alarm_raise,
    input  wire logic        alarm_fatal,
    output logic             motor_power_en,
    output logic             dyn_brake_on,
    output logic      [15:0] speed_cmd_eff,
    output logic             vib_filter2_en,
    output logic             p_only_ctrl,
    output logic             gain2_sel,
    output logic      [15:0] torque_limit,
    output logic      [15:0] gear_numerator,
    output logic      [1:0]  active_mode,
    output logic             dev_counter_clr,
    output logic             alarm_active
);
    localparam int PW = $bits(ssd_pkg::ssd_pins_s);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic [PW-1:0]          pin_raw;
    logic [PW-1:0]          pin_sync;
    ssd_pkg::ssd_pins_s     pin_q;
    logic [31:0]            cfg_ff;
    logic [31:0]            tlim_ff;
    logic [31:0]            gear_ff;
    logic [15:0]            spext_ff;
    logic [31:0]            rdata_ff;
    logic [31:0]            nxt_rdata;
    ssd_pkg::ssd_mode_e     cur_mode;
    ssd_pkg::ssd_servo_e    state_ff;
    ssd_pkg::ssd_servo_e    nxt_state;
    ssd_pkg::ssd_step_s     step;
    logic                   is_pos;
    logic                   is_spd;
    logic                   is_trq;
    logic                   zs_honoured;
    logic                   dir_rev;
    logic                   gsw_en;
    logic                   pulse_ok;
    logic                   dev_clr;
    logic                   alm_hit;
    logic                   alm_good;
    logic [15:0]            spd_base;
    logic [15:0]            tab_speed;
    logic [15:0]            nxt_speed;
    logic [23:0]            alm_cnt_ff;
    logic [23:0]            dev_count_ff;
    logic                   alm_ff;
    logic                   alm_fatal_ff;
    logic                   motor_ff;
    logic                   brake_ff;
    logic [15:0]            speed_ff;
    logic                   vib2_ff;
    logic                   p_only_ff;
    logic                   gain2_ff;
    logic [15:0]            tlim_out_ff;
    logic [15:0]            gear_out_ff;
    logic [1:0]             mode_ff;
    logic                   dev_clr_ff;

    // active mode from selection setting and switch input
    function automatic ssd_pkg::ssd_mode_e mode_of(input logic [2:0] sel,
                                                   input logic       sw);
        case (sel)
            `SSD_CM_POS:     mode_of = ssd_pkg::MODE_POS;
            `SSD_CM_SPD:     mode_of = ssd_pkg::MODE_SPD;
            `SSD_CM_TRQ:     mode_of = ssd_pkg::MODE_TRQ;
            `SSD_CM_POS_SPD: mode_of = sw ? ssd_pkg::MODE_SPD
                                          : ssd_pkg::MODE_POS;
            `SSD_CM_POS_TRQ: mode_of = sw ? ssd_pkg::MODE_TRQ
                                          : ssd_pkg::MODE_POS;
            `SSD_CM_SPD_TRQ: mode_of = sw ? ssd_pkg::MODE_TRQ
                                          : ssd_pkg::MODE_SPD;
            default:         mode_of = ssd_pkg::MODE_POS;
        endcase
    endfunction : mode_of

    // every pin passes two flip-flops before use
    assign pin_raw = {servo_on_in, alarm_reset_in, ctrl_mode_switch_in,
                      zero_speed_in, gain_switch_in, gear_num_sel_in,
                      dev_counter_clear_in, pulse_inhibit_in,
                      ld_rev_pulse_p, ld_fwd_pulse_p,
                      oc_rev_pulse, oc_fwd_pulse};

    for (genvar g = 0; g < PW; g++)
    begin : g_sync
        logic s1_ff;
        logic s2_ff;
        always_ff @(posedge core_clk)
        begin
            if (!rst_n)
            begin
                s1_ff <= 1'b0;
                s2_ff <= 1'b0;
            end
            else
            begin
                s1_ff <= pin_raw[g];
                s2_ff <= s1_ff;
            end
        end
        assign pin_sync[g] = s2_ff;
    end

    assign pin_q = ssd_pkg::ssd_pins_s'(pin_sync);

    // RULE17 mode switch gating
    assign cur_mode = mode_of(cfg_ff[`SSD_F_CMODE], pin_q.mode_sw);
    // RULE21 per-mode pin meaning
    assign is_pos = (cur_mode == ssd_pkg::MODE_POS);
    assign is_spd = (cur_mode == ssd_pkg::MODE_SPD);
    assign is_trq = (cur_mode == ssd_pkg::MODE_TRQ);

    // RULE1 zero-speed enable
    assign zs_honoured = (is_spd | is_trq)
                       & (cfg_ff[`SSD_F_ZSD] == `SSD_ZSD_ZERO);
    // RULE3 direction select
    assign dir_rev = is_spd & (cfg_ff[`SSD_F_ZSD] == `SSD_ZSD_DIR)
                   & pin_q.pin26;
    // RULE5 gain pin sharing
    assign gsw_en = (cfg_ff[`SSD_F_TLS] != `SSD_TLS_SWITCH);
    // RULE18 pulse inhibit gate
    assign pulse_ok = is_pos & (cfg_ff[`SSD_F_IPGEN] | pin_q.pin33);

    // RULE11 stored speed select
    ssd_speed_mem u_speed_mem (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (reg_wr && reg_addr == `SSD_REG_SPTAB),
        .wr_addr  (reg_wdata[`SSD_F_TIDX]),
        .wr_data  (reg_wdata[15:0]),
        .rd_addr  (is_spd ? {pin_q.pin28, pin_q.pin30, pin_q.pin33}
                          : 3'h0),
        .rd_data  (tab_speed)
    );

    // RULE19 pulse port select
    ssd_pulse_dec u_pulse_dec (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .fmt      (cfg_ff[`SSD_F_FMT]),
        .line_a   (cfg_ff[`SSD_F_PORT] ? pin_q.ld_a : pin_q.oc_a),
        .line_b   (cfg_ff[`SSD_F_PORT] ? pin_q.ld_b : pin_q.oc_b),
        .step     (step)
    );

    // speed source and clamp
    assign spd_base = (cfg_ff[`SSD_F_INTSP] & is_spd) ? tab_speed : spext_ff;
    always_comb
    begin
        nxt_speed = spd_base;
        if (dir_rev)
            nxt_speed = 16'(~spd_base + 16'h0001);
        // RULE2 zero-speed clamp
        if (zs_honoured & ~pin_q.pin26)
            nxt_speed = 16'h0000;
    end

    // decoded control outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            speed_ff    <= 16'h0000;
            vib2_ff     <= 1'b0;
            p_only_ff   <= 1'b0;
            gain2_ff    <= 1'b0;
            tlim_out_ff <= 16'h0000;
            gear_out_ff <= 16'h0000;
            mode_ff     <= 2'h0;
        end
        else
        begin
            speed_ff    <= nxt_speed;
            // RULE4 filter pair select
            vib2_ff     <= is_pos & cfg_ff[`SSD_F_VIB] & pin_q.pin26;
            // RULE6 proportional only
            p_only_ff   <= gsw_en & ~cfg_ff[`SSD_F_GMODE] & pin_q.pin27;
            // RULE7 gain set toggle
            gain2_ff    <= gsw_en & cfg_ff[`SSD_F_GMODE]
                         & ~cfg_ff[`SSD_F_GAUX][1]
                         & (pin_q.pin27 ^ cfg_ff[`SSD_F_GAUX][0]);
            // RULE8 torque limit switch
            tlim_out_ff <= (~gsw_en & pin_q.pin27) ? tlim_ff[31:16]
                                                   : tlim_ff[15:0];
            // RULE9 gear numerator select
            gear_out_ff <= (is_pos & pin_q.pin28) ? gear_ff[31:16]
                                                  : gear_ff[15:0];
            mode_ff     <= cur_mode;
        end
    end

    // RULE15 alarm reset hold count
    assign alm_hit  = pin_q.alarm_reset
                    & (alm_cnt_ff == 24'(ALM_RST_CYC - 1));
    assign alm_good = alm_hit & alm_ff & ~alm_fatal_ff;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            alm_cnt_ff <= 24'h00_0000;
        else if (!pin_q.alarm_reset)
            alm_cnt_ff <= 24'h00_0000;
        else if (alm_cnt_ff != 24'(ALM_RST_CYC))
            alm_cnt_ff <= 24'(alm_cnt_ff + 24'h00_0001);
    end

    // RULE16 alarm latch, fatal ones stay
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            alm_ff       <= 1'b0;
            alm_fatal_ff <= 1'b0;
        end
        else
        begin
            if (alarm_raise | alarm_fatal)
                alm_ff <= 1'b1;  // a new alarm beats the reset
            else if (alm_good)
                alm_ff <= 1'b0;
            if (alarm_fatal)
                alm_fatal_ff <= 1'b1;
        end
    end

    // RULE12 servo power state
    always_comb
    begin
        case (state_ff)
            ssd_pkg::SV_OFF:
                nxt_state = alm_ff ? ssd_pkg::SV_ALARM
                          : pin_q.servo_on ? ssd_pkg::SV_ON
                          : ssd_pkg::SV_OFF;
            ssd_pkg::SV_ON:
                nxt_state = alm_ff ? ssd_pkg::SV_ALARM
                          : pin_q.servo_on ? ssd_pkg::SV_ON
                          : ssd_pkg::SV_OFF;
            ssd_pkg::SV_ALARM:
                nxt_state = alm_ff ? ssd_pkg::SV_ALARM : ssd_pkg::SV_OFF;
            default:
                nxt_state = ssd_pkg::SV_OFF;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ssd_pkg::SV_OFF;
            motor_ff <= 1'b0;
            brake_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            motor_ff <= (nxt_state == ssd_pkg::SV_ON);
            // RULE13 braking at servo off
            brake_ff <= (nxt_state != ssd_pkg::SV_ON)
                      & cfg_ff[`SSD_F_STOP][0];
        end
    end

    // RULE14 deviation counter clear
    assign dev_clr = (is_pos & pin_q.pin30) | alm_good
                   | ((state_ff != ssd_pkg::SV_ON) & cfg_ff[`SSD_F_STOP][1]);
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dev_count_ff <= 24'h00_0000;
            dev_clr_ff   <= 1'b0;
        end
        else
        begin
            dev_clr_ff <= dev_clr;
            if (dev_clr)
                dev_count_ff <= 24'h00_0000;
            else if (pulse_ok & step.up)
                dev_count_ff <= 24'(dev_count_ff + 24'h00_0001);
            else if (pulse_ok & step.dn)
                dev_count_ff <= 24'(dev_count_ff - 24'h00_0001);
        end
    end

    // configuration register writes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg_ff   <= `SSD_CFG_RST;
            tlim_ff  <= `SSD_TLIM_RST;
            gear_ff  <= `SSD_GEAR_RST;
            spext_ff <= `SSD_SPEXT_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SSD_REG_CFG:   cfg_ff   <= reg_wdata;
                `SSD_REG_TLIM:  tlim_ff  <= reg_wdata;
                `SSD_REG_GEAR:  gear_ff  <= reg_wdata;
                `SSD_REG_SPEXT: spext_ff <= reg_wdata[15:0];
                default:        ;
            endcase
        end
    end

    // read decode, unmapped reads return zero
    always_comb
    begin
        case (reg_addr)
            `SSD_REG_CFG:   nxt_rdata = cfg_ff;
            `SSD_REG_TLIM:  nxt_rdata = tlim_ff;
            `SSD_REG_GEAR:  nxt_rdata = gear_ff;
            `SSD_REG_SPEXT: nxt_rdata = {16'h0000, spext_ff};
            `SSD_REG_STAT:  nxt_rdata = {23'h00_0000, vib2_ff, gain2_ff,
                                         p_only_ff, brake_ff, alm_fatal_ff,
                                         alm_ff, motor_ff, mode_ff};
            `SSD_REG_DEV:   nxt_rdata = {{8{dev_count_ff[23]}},
                                         dev_count_ff};
            default:        nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end

    assign reg_rdata       = rdata_ff;
    assign motor_power_en  = motor_ff;
    assign dyn_brake_on    = brake_ff;
    assign speed_cmd_eff   = speed_ff;
    assign vib_filter2_en  = vib2_ff;
    assign p_only_ctrl     = p_only_ff;
    assign gain2_sel       = gain2_ff;
    assign torque_limit    = tlim_out_ff;
    assign gear_numerator  = gear_out_ff;
    assign active_mode     = mode_ff;
    assign dev_counter_clr = dev_clr_ff;
    assign alarm_active    = alm_ff;

    // checks next to the decode above
    a_zero_ignored: assert property ( // RULE1
        (cfg_ff[`SSD_F_ZSD] == 2'h0) |=> speed_cmd_eff == $past(spd_base))
        else $error("speed changed with zero-speed input disabled");
    a_zero_clamp: assert property ( // RULE2
        (zs_honoured && !pin_q.pin26) |=> speed_cmd_eff == 16'h0000)
        else $error("speed not clamped to zero");
    a_dir_reverse: assert property ( // RULE3
        dir_rev |=> (speed_cmd_eff + $past(spd_base)) == 16'h0000)
        else $error("reverse direction not applied");
    a_vib_filter: assert property ( // RULE4
        (is_pos && cfg_ff[`SSD_F_VIB] && pin_q.pin26) |=> vib_filter2_en)
        else $error("second filter pair not selected");
    a_gain_pin_off: assert property ( // RULE5
        !gsw_en |=> !p_only_ctrl && !gain2_sel)
        else $error("gain switch acted while pin is torque switch");
    a_p_only: assert property ( // RULE6
        (gsw_en && !cfg_ff[`SSD_F_GMODE] && pin_q.pin27) |=> p_only_ctrl)
        else $error("proportional only not selected");
    a_gain_toggle: assert property ( // RULE7
        (gsw_en && cfg_ff[`SSD_F_GMODE] && cfg_ff[`SSD_F_GAUX] == 2'h0)
        |=> gain2_sel == $past(pin_q.pin27))
        else $error("gain set does not follow switch");
    a_torque_two: assert property ( // RULE8
        (!gsw_en && pin_q.pin27) |=> torque_limit == $past(tlim_ff[31:16]))
        else $error("second torque limit not applied");
    a_gear_two: assert property ( // RULE9
        (is_pos && pin_q.pin28) |=> gear_numerator == $past(gear_ff[31:16]))
        else $error("second gear numerator not applied");
    a_servo_off: assert property ( // RULE12
        (!pin_q.servo_on || alm_ff) |=> !motor_power_en)
        else $error("motor energised without servo on");
    a_stop_brake: assert property ( // RULE13
        (!pin_q.servo_on && cfg_ff[`SSD_F_STOP] == 2'h1)
        |=> dyn_brake_on ##1 dev_counter_clr == 1'b0 || is_pos)
        else $error("braking at servo off missing");
    a_dev_clear: assert property ( // RULE14
        (is_pos && pin_q.pin30) |=> dev_count_ff == 24'h00_0000
                                    && dev_counter_clr)
        else $error("deviation counter not cleared");
    a_alarm_reset: assert property ( // RULE15
        (alm_good && !alarm_raise && !alarm_fatal) |=> !alarm_active
                                    && dev_count_ff == 24'h00_0000)
        else $error("alarm reset did not clear alarm and counter");
    a_fatal_stays: assert property ( // RULE16
        alm_fatal_ff |=> alarm_active [*2])
        else $error("fatal alarm was cleared");
    a_mode_fixed: assert property ( // RULE17
        (cfg_ff[`SSD_F_CMODE] == `SSD_CM_SPD)
        |=> active_mode == ssd_pkg::MODE_SPD)
        else $error("fixed mode changed by switch input");
    a_pulse_drop: assert property ( // RULE18
        (!pulse_ok && !dev_clr) |=> $stable(dev_count_ff))
        else $error("inhibited pulse was counted");
endmodule : ssd_top

/* File: tb/ssd_host.sv */
`timescale 1ns/10ps
module ssd_host (
    input  wire logic core_clk,
    output logic      line_a,
    output logic      line_b
);
    // pulse lines rest low between trains
    initial
    begin
        line_a = 1'b0;
        line_b = 1'b0;
    end
    // pulse rate cap
    // 50 clocks a pulse keeps the train at 2 Mpps
    task automatic send(input int n, input logic fwd);
        repeat (n)
        begin
            repeat (25) @(posedge core_clk);
            line_a <= !fwd;
            line_b <= fwd;
            repeat (25) @(posedge core_clk);
            line_a <= 1'b0;
            line_b <= 1'b0;
        end
    endtask : send
    // quadrature steps 25 clocks apart, line b leads when forward
    task automatic quad(input int n, input logic fwd);
        repeat (n)
        begin
            repeat (25) @(posedge core_clk);
            if ((line_a == line_b) ^ !fwd)
                line_b <= !line_b;
            else
                line_a <= !line_a;
        end
    endtask : quad
endmodule : ssd_host

/* File: tb/ssd_top_tb.sv */
`timescale 1ns/10ps
module ssd_top_tb;
    logic        core_clk = 0;
    logic        rst_n = 0;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic [31:0] rd_v;
    logic [31:0] seed = 32'h46e5_e738;
    logic        zs = 0, gs = 0, gr = 0, cc = 0, pi = 0, ms = 0;
    logic        so = 0, ar = 0, alr = 0, alf = 0, la, lb;
    logic [31:0] rdata;
    logic [15:0] spd, tlim, gear;
    logic [1:0]  mode;
    logic        pwr, brk, f2, po, g2, clr, alm;
    int          mismatches = 0;
    int          checks_done = 0;
    int          dev_model = 0;
    // 100 MHz clock
    initial forever #5 core_clk = !core_clk;
    ssd_host host (.core_clk(core_clk), .line_a(la), .line_b(lb));
    ssd_top #(.ALM_RST_CYC(20)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .zero_speed_in(zs),
        .gain_switch_in(gs), .gear_num_sel_in(gr),
        .dev_counter_clear_in(cc), .pulse_inhibit_in(pi),
        .ctrl_mode_switch_in(ms), .servo_on_in(so), .alarm_reset_in(ar),
        .ld_rev_pulse_p(la), .ld_fwd_pulse_p(lb), .oc_rev_pulse(1'b0),
        .oc_fwd_pulse(1'b0), .alarm_raise(alr), .alarm_fatal(alf),
        .motor_power_en(pwr), .dyn_brake_on(brk), .speed_cmd_eff(spd),
        .vib_filter2_en(f2), .p_only_ctrl(po), .gain2_sel(g2),
        .torque_limit(tlim), .gear_numerator(gear), .active_mode(mode),
        .dev_counter_clr(clr), .alarm_active(alm));
    // next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_v = rdata;
    endtask : rd
    // pin changes need up to four edges to reach outputs
    task automatic settle();
        repeat (5) @(posedge core_clk);
        #1;
    endtask : settle
    // deviation count against the bench's running total
    task automatic chk_dev(input int delta);
        dev_model += delta;
        settle();
        rd(8'h18);
        chk(rd_v, dev_model);
    endtask : chk_dev
    // raise an alarm, then hold the reset input past the hold count
    task automatic alarm_try(input logic fatal);
        alr <= !fatal;
        alf <= fatal;
        settle();
        chk(alm, 1'b1);
        {alr, alf, ar} <= 3'b001; // held 30 cycles
        repeat (30) @(posedge core_clk);
        ar <= 1'b0;
        settle();
    endtask : alarm_try
    task automatic results();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // watchdog
    initial
    begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h00);
        chk(rd_v, 32'h0001_0000);
        rd(8'h08);
        chk(rd_v, 32'h0001_0001);
        rd(8'h1c);
        chk(rd_v, 32'h0000_0000);
        wr(8'h00, 32'h0011_0000);
        so <= 1'b1;
        settle();
        chk(pwr, 1'b1);
        chk(brk, 1'b0);
        so <= 1'b0;
        settle();
        chk(pwr, 1'b0);
        chk(brk, 1'b1);
        seed = lfsr(seed);
        wr(8'h04, seed);
        wr(8'h00, 32'h0001_0030);
        gs <= 1'b1;
        settle();
        chk(tlim, seed[31:16]);
        chk(po, 1'b0);
        gs <= 1'b0;
        settle();
        chk(tlim, seed[15:0]);
        seed = lfsr(seed);
        wr(8'h08, seed);
        gr <= 1'b1; // lines idle, quiet time shortened
        settle();
        chk(gear, seed[31:16]);
        seed = lfsr(seed);
        wr(8'h0c, seed);
        wr(8'h00, 32'h0001_1001);
        ms <= 1'b1;
        settle();
        chk(spd, 16'h0000);
        chk(mode, 2'h1);
        zs <= 1'b1;
        settle();
        chk(spd, seed[15:0]);
        wr(8'h10, 32'h0004_1234);
        wr(8'h00, 32'h0041_1001);
        settle();
        chk(spd, 16'h1234);
        wr(8'h00, 32'h0001_1002);
        settle();
        chk(spd, 16'(16'h0000 - seed[15:0]));
        wr(8'h00, 32'h0001_0004);
        gs <= 1'b1;
        settle();
        chk(f2, 1'b1);
        chk(po, 1'b1);
        wr(8'h00, 32'h0001_0040);
        settle();
        chk(g2, 1'b1);
        wr(8'h00, 32'h0007_0000);
        host.send(3, 1'b1);
        host.send(5, 1'b0);
        chk_dev(3 - 5);
        wr(8'h00, 32'h0003_0000);
        host.quad(8, 1'b1);
        host.quad(4, 1'b0);
        chk_dev(8 - 4);
        wr(8'h00, 32'h000b_0000);
        host.send(3, 1'b0);
        chk_dev(3);
        wr(8'h00, 32'h0006_0000);
        host.send(2, 1'b1);
        chk_dev(0);
        alarm_try(1'b0);
        chk(alm, 1'b0);
        chk_dev(-dev_model);
        alarm_try(1'b1);
        chk(alm, 1'b1);
        cc <= 1'b1;
        repeat (2000) settle(); // held past 100 us
        chk(clr, 1'b1);
        results();
    end
endmodule : ssd_top_tb
